// *** ext_irq_sfr.sv ***
// Extended interrupt register unit: source flags, enables, extended control and
// the Timer 2 count bytes, reached over the core's special-function register port.
// Assumes the core drives address, strobes and write data synchronously to ref_clk_in,
// and that the Timer 2 prescaler outside supplies a one-cycle count tick.

`timescale 1ns/1ps
`default_nettype none

module ext_irq_sfr
  import ext_irq_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  input  wire logic [7:0]  sfr_wdata_in,
  output logic      [7:0]  sfr_rdata_out,
  input  wire logic        source5_request_pin_low_in,
  input  wire logic        source4_request_pin_in,
  input  wire logic        source3_request_pin_low_in,
  input  wire logic        source2_request_pin_in,
  input  wire logic        power_fail_pin_in,
  input  wire logic        timer2_tick_in,
  output logic             source5_irq_out,
  output logic             source4_irq_out,
  output logic             source3_irq_out,
  output logic             source2_irq_out,
  output logic             power_fail_irq_out,
  output logic             serial1_baud_doubler_out,
  output logic      [15:0] timer2_count_bits_out,
  output logic             timer2_overflow_flag_out
);
  import ext_irq_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  // Flag and enable nibbles are ordered 5,4,3,2 from bit 3 down to bit 0.
  typedef struct packed {
    logic [3:0]  source_flags;
    logic [3:0]  source_enables;
    logic        serial1_baud_doubler;
    logic        power_fail_enable;
    logic        power_fail_flag;
    logic [15:0] count;
    logic        overflow;
    logic [7:0]  rdata;
  } sfr_state_t;

  sfr_state_t           state_ff;
  sfr_state_t           nxt_state;
  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] rise;
  logic [PIN_COUNT-1:0] fall;
  logic [3:0]           source_events;
  logic                 power_fail_event;
  logic [3:0]           irq_vector;

  // Address match shared by the write and read paths.
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  // ------------------------------------------------------------------
  // Pin edges
  // ------------------------------------------------------------------
  assign pins[PIN_SRC2] = source2_request_pin_in;
  assign pins[PIN_SRC3] = source3_request_pin_low_in;
  assign pins[PIN_SRC4] = source4_request_pin_in;
  assign pins[PIN_SRC5] = source5_request_pin_low_in;
  assign pins[PIN_PF]   = power_fail_pin_in;

  pin_edge_detect u_pin_edge_detect (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .pins_in    (pins),
    .rise_out   (rise),
    .fall_out   (fall)
  );

  // Active-low sources fire on falling edges, the others on rising edges.
  assign source_events[3] = fall[PIN_SRC5];  // [RQ4]
  assign source_events[2] = rise[PIN_SRC4];  // [RQ5]
  assign source_events[1] = fall[PIN_SRC3];  // [RQ6]
  assign source_events[0] = rise[PIN_SRC2];  // [RQ7]
  assign power_fail_event = rise[PIN_PF];

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  // A pin event in the same cycle as a software clear wins, so no edge is lost.
  // The read image is taken before the same-cycle write lands.
  always_comb begin
    nxt_state          = state_ff;
    nxt_state.overflow = 1'b0;

    // Source flags: writable, set by pins, cleared only by software.
    if (sfr_wr_in && addr_hit(sfr_addr_in, ADDR_SOURCE_FLAGS)) begin  // [RQ3]
      nxt_state.source_flags = sfr_wdata_in[FLAG_FIELD_LSB +: 4];  // [RQ8] [RQ9]
    end
    nxt_state.source_flags = nxt_state.source_flags | source_events;

    // Extended control: bits 7,5,4 held; bit 6 and low nibble fixed.
    if (sfr_wr_in && addr_hit(sfr_addr_in, ADDR_EXT_CONTROL)) begin  // [RQ10]
      nxt_state.serial1_baud_doubler = sfr_wdata_in[BAUD_DOUBLER_BIT];
      nxt_state.power_fail_enable    = sfr_wdata_in[PF_ENABLE_BIT];
      nxt_state.power_fail_flag      = sfr_wdata_in[PF_FLAG_BIT];  // [RQ15]
    end
    nxt_state.power_fail_flag = nxt_state.power_fail_flag | power_fail_event;  // [RQ13]

    // Enables: only the low nibble stores; bit 4 ignores writes.
    if (sfr_wr_in && addr_hit(sfr_addr_in, ADDR_SOURCE_ENABLES)) begin  // [RQ16]
      nxt_state.source_enables = sfr_wdata_in[ENABLE_FIELD_LSB +: 4];  // [RQ17]
    end

    // Timer 2 count: a byte write overrides the tick for that byte.
    if (timer2_tick_in) begin
      nxt_state.count    = state_ff.count + 16'h0001;
      nxt_state.overflow = (state_ff.count == COUNT_ROLLOVER);  // [RQ19]
    end
    if (sfr_wr_in && addr_hit(sfr_addr_in, ADDR_COUNT_LOW)) begin
      nxt_state.count[7:0] = sfr_wdata_in;  // [RQ1]
    end
    if (sfr_wr_in && addr_hit(sfr_addr_in, ADDR_COUNT_HIGH)) begin
      nxt_state.count[15:8] = sfr_wdata_in;  // [RQ2]
    end

    // Read image, registered so read data comes from a flip-flop.
    if (sfr_rd_in) begin
      if (addr_hit(sfr_addr_in, ADDR_SOURCE_FLAGS)) begin
        nxt_state.rdata = {state_ff.source_flags, FLAGS_FIXED_LOW};  // [RQ3]
      end else if (addr_hit(sfr_addr_in, ADDR_EXT_CONTROL)) begin
        nxt_state.rdata = {state_ff.serial1_baud_doubler, CONTROL_FIXED_BIT6,
                           state_ff.power_fail_enable, state_ff.power_fail_flag,
                           CONTROL_FIXED_LOW};  // [RQ10]
      end else if (addr_hit(sfr_addr_in, ADDR_SOURCE_ENABLES)) begin
        nxt_state.rdata = {ENABLES_FIXED_HIGH, state_ff.source_enables};  // [RQ18]
      end else if (addr_hit(sfr_addr_in, ADDR_COUNT_LOW)) begin
        nxt_state.rdata = state_ff.count[7:0];  // [RQ1]
      end else if (addr_hit(sfr_addr_in, ADDR_COUNT_HIGH)) begin
        nxt_state.rdata = state_ff.count[15:8];  // [RQ2]
      end else begin
        nxt_state.rdata = UNMAPPED_READ;
      end
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= '{source_flags:         RESET_SOURCE_FLAGS[7:4],
                    source_enables:       RESET_SOURCE_ENABLES[3:0],
                    serial1_baud_doubler: RESET_EXT_CONTROL[BAUD_DOUBLER_BIT],
                    power_fail_enable:    RESET_EXT_CONTROL[PF_ENABLE_BIT],
                    power_fail_flag:      RESET_EXT_CONTROL[PF_FLAG_BIT],
                    count:                {RESET_COUNT_HIGH, RESET_COUNT_LOW},
                    overflow:             1'b0,
                    rdata:                UNMAPPED_READ};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Requests are levels: the core keeps seeing one until software clears the flag,
  // which is why an unserviced flag re-enters the handler.
  assign irq_vector               = state_ff.source_flags & state_ff.source_enables;  // [RQ20]
  assign source5_irq_out          = irq_vector[3];
  assign source4_irq_out          = irq_vector[2];
  assign source3_irq_out          = irq_vector[1];
  assign source2_irq_out          = irq_vector[0];
  assign power_fail_irq_out       = state_ff.power_fail_flag &
                                    state_ff.power_fail_enable;  // [RQ12] [RQ14]
  assign serial1_baud_doubler_out = state_ff.serial1_baud_doubler;  // [RQ11]
  assign timer2_count_bits_out    = state_ff.count;
  assign timer2_overflow_flag_out = state_ff.overflow;
  assign sfr_rdata_out            = state_ff.rdata;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence flag_wr_s;
    sfr_wr_in && addr_hit(sfr_addr_in, ADDR_SOURCE_FLAGS);
  endsequence

  sequence src5_edge_s;
    source_events[3] ##1 1'b1;
  endsequence

  // A detected falling edge on source 5 leaves its flag set next cycle.
  src5_edge_sets_a: assert property (src5_edge_s |-> state_ff.source_flags[3]) // [RQ4]
    else $error("source 5 edge did not set its flag");

  src4_edge_sets_a: assert property (source_events[2] |=> state_ff.source_flags[2]) // [RQ5]
    else $error("source 4 edge did not set its flag");

  // Without a flag write, no flag ever drops.
  flag_no_hwclear_a: assert property (
      !(sfr_wr_in && addr_hit(sfr_addr_in, ADDR_SOURCE_FLAGS))
      |=> (state_ff.source_flags & $past(state_ff.source_flags))
          == $past(state_ff.source_flags)) // [RQ8]
    else $error("source flag cleared by hardware");

  // Writing one to an enabled flag raises its request next cycle.
  sw_set_irq_a: assert property (
      flag_wr_s ##0 sfr_wdata_in[7] ##0 state_ff.source_enables[3]
      ##0 !(sfr_wr_in && addr_hit(sfr_addr_in, ADDR_SOURCE_ENABLES))
      |=> source5_irq_out) // [RQ9]
    else $error("software set did not raise source 5 request");

  irq_gating_a: assert property (
      source2_irq_out == (state_ff.source_flags[0] && state_ff.source_enables[0])) // [RQ20]
    else $error("source 2 request does not follow flag and enable");

  pf_gate_a: assert property (!state_ff.power_fail_enable |-> !power_fail_irq_out) // [RQ12]
    else $error("power-fail request while disabled");

  pf_pending_a: assert property (
      power_fail_irq_out && !sfr_wr_in |=> power_fail_irq_out) // [RQ14]
    else $error("power-fail request dropped without software action");

  pf_event_sets_a: assert property (power_fail_event |=> state_ff.power_fail_flag) // [RQ13]
    else $error("power-fail event did not set flag");

  enable_read_a: assert property (
      sfr_rd_in && addr_hit(sfr_addr_in, ADDR_SOURCE_ENABLES)
      |=> sfr_rdata_out[7:4] == ENABLES_FIXED_HIGH) // [RQ18]
    else $error("enable register high bits read wrong");

  // A low-byte write in the wrap cycle overrides the low byte, so it is left out here.
  rollover_flag_a: assert property (
      timer2_tick_in && state_ff.count == COUNT_ROLLOVER
      && !(sfr_wr_in && addr_hit(sfr_addr_in, ADDR_COUNT_LOW))
      |=> timer2_overflow_flag_out && timer2_count_bits_out[7:0] != 8'hff) // [RQ19]
    else $error("count rollover did not raise overflow");

  baud_follow_a: assert property (
      sfr_wr_in && addr_hit(sfr_addr_in, ADDR_EXT_CONTROL)
      |=> serial1_baud_doubler_out == $past(sfr_wdata_in[BAUD_DOUBLER_BIT])) // [RQ11]
    else $error("baud doubler did not follow write");

  // Source 3 and source 2 edges set their flags one cycle after the event pulse.
  src3_edge_sets_a: assert property (source_events[1] |=> state_ff.source_flags[1]) // [RQ6]
    else $error("source 3 edge did not set its flag");

  src2_edge_sets_a: assert property (source_events[0] |=> state_ff.source_flags[0]) // [RQ7]
    else $error("source 2 edge did not set its flag");

  // A zero written to an enable blocks the request, whatever the flag holds.
  enable_block_a: assert property (
      sfr_wr_in && addr_hit(sfr_addr_in, ADDR_SOURCE_ENABLES) && !sfr_wdata_in[3]
      |=> !source5_irq_out) // [RQ17]
    else $error("source 5 request while its enable was written zero");

  // Writing one to the power-fail flag with its gate open raises the request.
  pf_sw_set_a: assert property (
      sfr_wr_in && addr_hit(sfr_addr_in, ADDR_EXT_CONTROL)
      && sfr_wdata_in[PF_ENABLE_BIT] && sfr_wdata_in[PF_FLAG_BIT]
      |=> power_fail_irq_out) // [RQ15]
    else $error("software power-fail set did not raise request");

  // Fixed bits of the control and flag registers read back at their tied values.
  control_read_a: assert property (
      sfr_rd_in && addr_hit(sfr_addr_in, ADDR_EXT_CONTROL)
      |=> sfr_rdata_out[6] && sfr_rdata_out[3:0] == CONTROL_FIXED_LOW) // [RQ10]
    else $error("control register fixed bits read wrong");

  flags_read_a: assert property (
      sfr_rd_in && addr_hit(sfr_addr_in, ADDR_SOURCE_FLAGS)
      |=> sfr_rdata_out[3:0] == FLAGS_FIXED_LOW) // [RQ3]
    else $error("flag register fixed bits read wrong");

  // An edge pulse never repeats on the next cycle, so one pin edge sets a flag once.
  edge_once_a: assert property ((source_events & $past(source_events)) == 4'h0) // [RQ21]
    else $error("source event pulse lasted more than one cycle");

endmodule

`default_nettype wire

// *** ext_irq_pkg.sv ***
// Constants shared by the extended interrupt register unit and its pin edge detector.
// Assumes a single core clock and an active-low asynchronous reset in every user.
//
// Functional notes
// [RQ1] Timer 2 count low byte at address cch, read/write, resets to 00.
// [RQ2] Timer 2 count high byte at address cdh, read/write, resets to 00.
// [RQ3] Source flag register at 91h resets to 08; top nibble writable, low nibble read-only.
// [RQ4] Falling edge on active-low source 5 pin sets flag bit 7.
// [RQ5] Rising edge on source 4 pin sets flag bit 6.
// [RQ6] Falling edge on active-low source 3 pin sets flag bit 5.
// [RQ7] Rising edge on source 2 pin sets flag bit 4.
// [RQ8] Hardware never clears source flags; software clears each by writing zero.
// [RQ9] Software writing one to a source flag raises its request when enabled.
// [RQ10] Extended control register at d8h resets to 40; bits 7-4 writable, 3-0 read-only. The unit holds bit 6 at one and ignores writes to it.
// [RQ11] Control bit 7 set doubles the second serial port baud rate.
// [RQ12] Control bit 5 gates power-fail requests; zero suppresses, one allows.
// [RQ13] Control bit 4 is the power-fail flag, set by a power-fail pin event.
// [RQ14] Power-fail request stays pending while its flag is set; software must clear it.
// [RQ15] Software writing one to the power-fail flag raises a request when enabled.
// [RQ16] Enable register at e8h resets to e0; top nibble read-only, low nibble writable.
// [RQ17] Enable bits 3 to 0 enable sources 5, 4, 3, 2 respectively.
// [RQ18] Enable bits 7-5 read one; bit 4 reads zero and ignores writes.
// [RQ19] Timer 2 overflow flag is set when the 16-bit count rolls over from ffff.
// [RQ20] Each source request is high exactly while its flag and enable are both one.
// [RQ21] Pin edges come from synchronized samples compared on successive clocks, once per edge.

package ext_irq_pkg;

  // ------------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_SOURCE_FLAGS   = 8'h91;
  localparam logic [7:0] ADDR_COUNT_LOW      = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH     = 8'hcd;
  localparam logic [7:0] ADDR_EXT_CONTROL    = 8'hd8;
  localparam logic [7:0] ADDR_SOURCE_ENABLES = 8'he8;

  // ------------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------------
  localparam logic [7:0]  RESET_SOURCE_FLAGS   = 8'h08;
  localparam logic [7:0]  RESET_COUNT_LOW      = 8'h00;
  localparam logic [7:0]  RESET_COUNT_HIGH     = 8'h00;
  localparam logic [7:0]  RESET_EXT_CONTROL    = 8'h40;
  localparam logic [7:0]  RESET_SOURCE_ENABLES = 8'he0;
  localparam logic [7:0]  UNMAPPED_READ        = 8'h00;
  localparam logic [15:0] COUNT_ROLLOVER       = 16'hffff;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int FLAG_FIELD_LSB    = 4;  // Source flags in bits 7:4.
  localparam int ENABLE_FIELD_LSB  = 0;  // Source enables in bits 3:0.
  localparam int BAUD_DOUBLER_BIT  = 7;
  localparam int PF_ENABLE_BIT     = 5;
  localparam int PF_FLAG_BIT       = 4;
  localparam logic [3:0] FLAGS_FIXED_LOW    = 4'h8;  // Bit 3 reads one, 2-0 zero.
  localparam logic [3:0] CONTROL_FIXED_LOW  = 4'h0;
  localparam logic [3:0] ENABLES_FIXED_HIGH = 4'he;  // Bits 7-5 one, bit 4 zero.
  localparam logic       CONTROL_FIXED_BIT6 = 1'b1;

  // ------------------------------------------------------------------
  // Pin vector layout inside the unit
  // ------------------------------------------------------------------
  localparam int PIN_COUNT   = 5;
  localparam int PIN_SRC2    = 0;
  localparam int PIN_SRC3    = 1;
  localparam int PIN_SRC4    = 2;
  localparam int PIN_SRC5    = 3;
  localparam int PIN_PF      = 4;
  localparam logic [4:0] PIN_RESET_LEVEL = 5'h0a;  // Idle level: active-low pins high.

endpackage

// *** pin_edge_detect.sv ***
// Pin synchronizer and edge detector for the external request pins.
// Assumes pins are asynchronous to ref_clk_in; outputs are one-cycle pulses on that clock.

`timescale 1ns/1ps
`default_nettype none

module pin_edge_detect
  import ext_irq_pkg::*;
(
  input  wire logic                 ref_clk_in,
  input  wire logic                 resetn_in,
  input  wire logic [PIN_COUNT-1:0] pins_in,
  output logic      [PIN_COUNT-1:0] rise_out,
  output logic      [PIN_COUNT-1:0] fall_out
);
  import ext_irq_pkg::*;

  typedef struct packed {
    logic [PIN_COUNT-1:0] meta;
    logic [PIN_COUNT-1:0] stage2;
    logic [PIN_COUNT-1:0] stage3;
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;
  } edge_state_t;

  edge_state_t state_ff;
  edge_state_t nxt_state;

  // ------------------------------------------------------------------
  // Edge qualification
  // ------------------------------------------------------------------
  // The first stage feeds only the second. A level change is accepted once stages two
  // and three agree, so a glitch of one sample never produces an edge.
  always_comb begin
    nxt_state        = state_ff;
    nxt_state.meta   = pins_in;
    nxt_state.stage2 = state_ff.meta;
    nxt_state.stage3 = state_ff.stage2;
    for (int i = 0; i < PIN_COUNT; i++) begin
      nxt_state.rise[i] = 1'b0;
      nxt_state.fall[i] = 1'b0;
      if (state_ff.stage2[i] == state_ff.stage3[i] &&
          state_ff.stage3[i] != state_ff.level[i]) begin  // [RQ21]
        nxt_state.level[i] = state_ff.stage3[i];
        nxt_state.rise[i]  = state_ff.stage3[i];
        nxt_state.fall[i]  = ~state_ff.stage3[i];
      end
    end
  end

  // Reset loads the idle level so no edge fires when reset is released.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= '{meta: PIN_RESET_LEVEL, stage2: PIN_RESET_LEVEL, stage3: PIN_RESET_LEVEL,
                    level: PIN_RESET_LEVEL, rise: '0, fall: '0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rise_out = state_ff.rise;
  assign fall_out = state_ff.fall;

endmodule

`default_nettype wire

// *** core_pin_model.sv ***
// Model of the core's special-function register port and the external request pins.
// Assumes one caller at a time; every request starts just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module core_pin_model
  import ext_irq_pkg::*;
(
  input  wire logic                 ref_clk_in,
  input  wire logic [7:0]           sfr_rdata_in,
  output logic      [7:0]           sfr_addr_out,
  output logic                      sfr_wr_out,
  output logic                      sfr_rd_out,
  output logic      [7:0]           sfr_wdata_out,
  output logic      [PIN_COUNT-1:0] pins_out
);
  // ------------------------------------------------------------
  // Idle state
  // ------------------------------------------------------------
  // Pins start at their idle level so reset release makes no event.
  initial begin
    sfr_addr_out  = 8'h00;
    sfr_wr_out    = 1'b0;
    sfr_rd_out    = 1'b0;
    sfr_wdata_out = 8'h00;
    pins_out      = PIN_RESET_LEVEL;
  end

  // One write, taken at the edge after the strobe rises.
  // Data is inverted once released, so a stale byte never looks valid.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    sfr_addr_out  <= a;
    sfr_wdata_out <= d;
    sfr_wr_out    <= 1'b1;
    @(posedge ref_clk_in);
    sfr_wr_out    <= 1'b0;
    sfr_wdata_out <= ~d;
    #1;
  endtask

  // One read; data is registered, so it is taken after the taking edge settles.
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    sfr_addr_out <= a;
    sfr_rd_out   <= 1'b1;
    @(posedge ref_clk_in);
    sfr_rd_out   <= 1'b0;
    #1;
    d = sfr_rdata_in;
  endtask

  // A pin change held 8 cycles, longer than the 3 cycle filter and the flag latency.
  task pin(input int idx, input logic lvl);
    @(posedge ref_clk_in);
    pins_out[idx] <= lvl;
    repeat (8) @(posedge ref_clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench for the extended interrupt register unit.
// Assumes core_pin_model plays the core and the pins; the bench drives reset and ticks.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ext_irq_pkg::*;
  logic                 ref_clk_in = 1'b0;
  logic                 resetn_in = 1'b0;
  logic                 timer2_tick_in = 1'b0;
  logic [7:0]           sfr_addr, sfr_wdata, sfr_rdata, rdv;
  logic                 sfr_wr, sfr_rd, pf_irq, doubler, ovf;
  logic [3:0]           irqs;
  logic [PIN_COUNT-1:0] pins;
  logic [15:0]          count;
  int                   fails = 0;
  int                   tests_run = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  core_pin_model core (.ref_clk_in(ref_clk_in), .sfr_rdata_in(sfr_rdata),
    .sfr_addr_out(sfr_addr), .sfr_wr_out(sfr_wr), .sfr_rd_out(sfr_rd),
    .sfr_wdata_out(sfr_wdata), .pins_out(pins));

  ext_irq_sfr dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .sfr_addr_in(sfr_addr),
    .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd), .sfr_wdata_in(sfr_wdata), .sfr_rdata_out(sfr_rdata),
    .source5_request_pin_low_in(pins[PIN_SRC5]), .source4_request_pin_in(pins[PIN_SRC4]),
    .source3_request_pin_low_in(pins[PIN_SRC3]), .source2_request_pin_in(pins[PIN_SRC2]),
    .power_fail_pin_in(pins[PIN_PF]), .timer2_tick_in(timer2_tick_in),
    .source5_irq_out(irqs[3]), .source4_irq_out(irqs[2]), .source3_irq_out(irqs[1]),
    .source2_irq_out(irqs[0]), .power_fail_irq_out(pf_irq),
    .serial1_baud_doubler_out(doubler), .timer2_count_bits_out(count),
    .timer2_overflow_flag_out(ovf));

  // ------------------------------------------------------------
  // Comparison and bus helpers
  // ------------------------------------------------------------
  task check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    core.rd(a, rdv);
    check($sformatf("register %h", a), {8'h00, exp}, {8'h00, rdv});
  endtask

  // One tick taken at the next edge; results looked at once that edge settles.
  task tick;
    @(posedge ref_clk_in);
    timer2_tick_in <= 1'b1;
    @(posedge ref_clk_in);
    timer2_tick_in <= 1'b0;
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task reset_values;
    rd_chk(ADDR_COUNT_LOW, 8'h00);
    rd_chk(ADDR_COUNT_HIGH, 8'h00);
    rd_chk(ADDR_SOURCE_FLAGS, 8'h08);
    rd_chk(ADDR_EXT_CONTROL, 8'h40);
    rd_chk(ADDR_SOURCE_ENABLES, 8'he0);
    rd_chk(8'h92, 8'h00);
    check("outputs after reset", 16'h0000, {10'h000, irqs, pf_irq, doubler});
  endtask

  // All ones then all zeros: read-only bits keep their fixed values.
  task access_kinds;
    core.wr(ADDR_SOURCE_ENABLES, 8'hff);
    core.wr(ADDR_SOURCE_FLAGS, 8'hff);
    core.wr(ADDR_EXT_CONTROL, 8'hff);
    core.wr(ADDR_COUNT_LOW, 8'ha5);
    core.wr(ADDR_COUNT_HIGH, 8'h5a);
    core.wr(8'h92, 8'hff);
    check("forced requests", 16'h003f, {10'h000, irqs, pf_irq, doubler});
    check("count bits", 16'h5aa5, count);
    rd_chk(ADDR_SOURCE_ENABLES, 8'hef);
    rd_chk(ADDR_SOURCE_FLAGS, 8'hf8);
    rd_chk(ADDR_EXT_CONTROL, 8'hf0);
    rd_chk(ADDR_COUNT_LOW, 8'ha5);
    rd_chk(ADDR_COUNT_HIGH, 8'h5a);
    rd_chk(8'h92, 8'h00);
    core.wr(ADDR_SOURCE_FLAGS, 8'h00);
    core.wr(ADDR_EXT_CONTROL, 8'h00);
    core.wr(ADDR_SOURCE_ENABLES, 8'h00);
    core.wr(ADDR_COUNT_LOW, 8'h00);
    core.wr(ADDR_COUNT_HIGH, 8'h00);
    check("cleared requests", 16'h0000, {10'h000, irqs, pf_irq, doubler});
    rd_chk(ADDR_SOURCE_FLAGS, 8'h08);
    rd_chk(ADDR_EXT_CONTROL, 8'h40);
    rd_chk(ADDR_SOURCE_ENABLES, 8'he0);
  endtask

  // Pin index i is source 2+i; the flag sits at bit 4+i, the enable at bit i.
  // The flag is cleared while the pin is still active, so a level-sensitive flag shows up.
  task pin_edges;
    int i;
    for (i = 0; i < 4; i++) begin
      core.pin(i, ~PIN_RESET_LEVEL[i]);
      rd_chk(ADDR_SOURCE_FLAGS, 8'h08 | (8'h10 << i));
      check("masked request", 16'h0000, {12'h000, irqs});
      core.wr(ADDR_SOURCE_ENABLES, 8'h01 << i);
      check("enabled request", {12'h000, 4'h1 << i}, {12'h000, irqs});
      rd_chk(ADDR_SOURCE_FLAGS, 8'h08 | (8'h10 << i));
      core.wr(ADDR_SOURCE_FLAGS, 8'h00);
      rd_chk(ADDR_SOURCE_FLAGS, 8'h08);
      check("cleared request", 16'h0000, {12'h000, irqs});
      core.pin(i, PIN_RESET_LEVEL[i]);
      rd_chk(ADDR_SOURCE_FLAGS, 8'h08);
      core.wr(ADDR_SOURCE_ENABLES, 8'h00);
    end
  endtask

  task power_fail;
    core.pin(PIN_PF, 1'b1);
    rd_chk(ADDR_EXT_CONTROL, 8'h50);
    check("gated power fail", 16'h0000, {15'h0000, pf_irq});
    core.wr(ADDR_EXT_CONTROL, 8'h30);
    core.pin(PIN_PF, 1'b0);
    check("pending power fail", 16'h0001, {15'h0000, pf_irq});
    rd_chk(ADDR_EXT_CONTROL, 8'h70);
    core.wr(ADDR_EXT_CONTROL, 8'h20);
    check("serviced power fail", 16'h0000, {15'h0000, pf_irq});
    rd_chk(ADDR_EXT_CONTROL, 8'h60);
  endtask

  // A carry into the high byte must not flag; only the wrap from ffff does, for one cycle.
  task timer_roll;
    core.wr(ADDR_COUNT_LOW, 8'hff);
    tick;
    check("carry count", 16'h0100, count);
    check("carry overflow", 16'h0000, {15'h0000, ovf});
    core.wr(ADDR_COUNT_LOW, 8'hff);
    core.wr(ADDR_COUNT_HIGH, 8'hff);
    tick;
    check("wrap count", 16'h0000, count);
    check("wrap overflow", 16'h0001, {15'h0000, ovf});
    @(posedge ref_clk_in);
    #1;
    check("overflow pulse end", 16'h0000, {15'h0000, ovf});
    rd_chk(ADDR_COUNT_HIGH, 8'h00);
  endtask

  task results;
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    reset_values;
    access_kinds;
    pin_edges;
    power_fail;
    timer_roll;
    results;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    fails++;
    $display("MISMATCH run length expected done seen hang");
    results;
  end
endmodule
`default_nettype wire
